// ---- rsh_pkg.sv ----
`default_nettype none

package rsh_pkg;

   // Register bus geometry.
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;

   // Register offsets.
   localparam logic [11:0] OFS_RX_MODE  = 12'h01A;
   localparam logic [11:0] OFS_SE_PD    = 12'h01B;
   localparam logic [11:0] OFS_SWITCH   = 12'h01C;
   localparam logic [11:0] OFS_DIVP_LO  = 12'h010;
   localparam logic [11:0] OFS_DIVP_HI  = 12'h011;
   localparam logic [11:0] OFS_DIVS_LO  = 12'h012;
   localparam logic [11:0] OFS_DIVS_HI  = 12'h013;
   localparam logic [11:0] OFS_STATUS   = 12'h020;
   localparam logic [11:0] OFS_PWR      = 12'h233;

   // Field positions.
   localparam int unsigned BIT_OSC_MODE_LO = 0;
   localparam int unsigned BIT_PRI_SE      = 5;
   localparam int unsigned BIT_SEC_SE      = 6;
   localparam int unsigned BIT_PRI_SE_PD   = 0;
   localparam int unsigned BIT_SEC_SE_PD   = 1;
   localparam int unsigned BIT_MODE_LO     = 0;
   localparam int unsigned BIT_MAN_SEL     = 2;
   localparam int unsigned BIT_HOLD_MID    = 6;
   localparam int unsigned BIT_INDEP_DIV   = 7;
   localparam int unsigned BIT_LOOP_PD     = 2;

   // Switchover modes held in the switch register.
   localparam logic [1:0] MODE_MAN_REG  = 2'h0;
   localparam logic [1:0] MODE_MAN_PIN  = 2'h1;
   localparam logic [1:0] MODE_AUTO_NR  = 2'h2;
   localparam logic [1:0] MODE_AUTO_REV = 2'h3;

   // Values after reset.
   localparam logic [7:0] RST_REG    = 8'h00;
   localparam logic [9:0] RST_DIV    = 10'h001;
   localparam logic [1:0] RST_SE_PD  = 2'h3;

   // Presence window in oscillator clock cycles.
   localparam logic [11:0] MON_WINDOW = 12'h800;

   typedef enum logic [1:0] {
      act_pri  = 2'b00,
      act_sec  = 2'b01,
      act_hold = 2'b10
   } rsh_act_e;

   typedef struct packed {
      rsh_act_e        act;
      logic [7:0]      reg_rx;
      logic [7:0]      reg_sepd;
      logic [7:0]      reg_sw;
      logic [7:0]      reg_pwr;
      logic [9:0]      div_pri;
      logic [9:0]      div_sec;
      logic [1:0]      ref_prev;
      logic [1:0][9:0] edge_cnt;
      logic [1:0]      tick;
      logic [11:0]     win_cnt;
      logic [1:0]      seen;
      logic [1:0]      present;
      logic            holdover;
      logic            sel_sec;
      logic            cp_tri;
      logic            cp_mid;
      logic            resync;
      logic [1:0]      diff_pd;
      logic [1:0]      se_pd;
      logic            osc_pd;
      logic [1:0]      osc_mode;
      logic [7:0]      rdata;
   } rsh_state_s;

endpackage

`default_nettype wire

// ---- rsh_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - In the automatic modes, with only one reference present, that reference becomes active.
// - With both present, one is active and the other is held as backup.
// - In the automatic modes, when the active reference fails, switch to the backup if it is present.
// - Presence is judged on each reference after its input divider and steers switching.
// - Manual selection comes from a register bit or from the select pin.
// - Automatic modes leave the primary when it vanishes and the secondary is present.
// - Nonrevertive mode stays on secondary until the secondary vanishes.
// - Revertive mode returns to primary as soon as primary is present again.
// - With no reference present, enter holdover on the oscillator.
// - In holdover the charge pump is tristated by default.
// - Leave holdover when a reference appears (the selected one in manual modes) and pulse a resynchronise strobe.
// - A switch register bit forces the pump to mid-supply instead in holdover.
// - Each reference has its own divider, one to 1023.
// - Secondary divider uses the primary value unless independent division is set.
// - Differential receiver is off when not selected or the input loop is off.
// - Single-ended buffer is off on loop power-down, its own bit, or differential use.
// - A two-bit field sets the oscillator-input receiver mode.
// - Oscillator-input receiver is off while the loop power-down bit is one.
module rsh_ctrl #(
   parameter logic [11:0] MON_WINDOW = rsh_pkg::MON_WINDOW
) (
   input  wire logic                         core_clk,
   input  wire logic                         nrst,
   input  wire logic [rsh_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [rsh_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [rsh_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic                         primary_reference,
   input  wire logic                         secondary_reference,
   input  wire logic                         ref_select_pin,
   output logic                              active_secondary,
   output logic                              holdover,
   output logic                              input_loop_resync,
   output logic                              cp_tristate,
   output logic                              cp_midsupply,
   output logic      [1:0]                   ref_present,
   output logic      [1:0]                   ref_div_tick,
   output logic      [1:0]                   diff_rx_pd,
   output logic      [1:0]                   se_buf_pd,
   output logic                              oscillator_input_pd,
   output logic      [1:0]                   oscillator_input_mode
);

   rsh_pkg::rsh_state_s q;
   rsh_pkg::rsh_state_s nxt_q;

   logic       loop_pd;
   logic [1:0] ref_in;
   logic [1:0] mode;
   logic       want_sec;
   logic [1:0] pres;
   logic [9:0] div_eff [2];

   assign ref_in = {secondary_reference, primary_reference};

   // Clamp a zero divisor to one so the divider never stalls.
   function automatic logic [9:0] div_limit(input logic [9:0] d);
      div_limit = (d == 10'h000) ? 10'h000 : d - 10'h001;
   endfunction

   always_comb begin
      nxt_q = q;
      nxt_q.tick = 2'b00;
      nxt_q.resync = 1'b0;

      // Register writes.
      if (reg_wr) begin
         if (reg_addr == rsh_pkg::OFS_RX_MODE) begin
            nxt_q.reg_rx = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_SE_PD) begin
            nxt_q.reg_sepd = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_SWITCH) begin
            nxt_q.reg_sw = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_PWR) begin
            nxt_q.reg_pwr = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_DIVP_LO) begin
            nxt_q.div_pri[7:0] = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_DIVP_HI) begin
            nxt_q.div_pri[9:8] = reg_wdata[1:0];
         end else if (reg_addr == rsh_pkg::OFS_DIVS_LO) begin
            nxt_q.div_sec[7:0] = reg_wdata;
         end else if (reg_addr == rsh_pkg::OFS_DIVS_HI) begin
            nxt_q.div_sec[9:8] = reg_wdata[1:0];
         end
      end

      // Register reads; unmapped addresses answer zero.
      nxt_q.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == rsh_pkg::OFS_RX_MODE) begin
            nxt_q.rdata = q.reg_rx;
         end else if (reg_addr == rsh_pkg::OFS_SE_PD) begin
            nxt_q.rdata = q.reg_sepd;
         end else if (reg_addr == rsh_pkg::OFS_SWITCH) begin
            nxt_q.rdata = q.reg_sw;
         end else if (reg_addr == rsh_pkg::OFS_PWR) begin
            nxt_q.rdata = q.reg_pwr;
         end else if (reg_addr == rsh_pkg::OFS_DIVP_LO) begin
            nxt_q.rdata = q.div_pri[7:0];
         end else if (reg_addr == rsh_pkg::OFS_DIVP_HI) begin
            nxt_q.rdata = {6'h00, q.div_pri[9:8]};
         end else if (reg_addr == rsh_pkg::OFS_DIVS_LO) begin
            nxt_q.rdata = q.div_sec[7:0];
         end else if (reg_addr == rsh_pkg::OFS_DIVS_HI) begin
            nxt_q.rdata = {6'h00, q.div_sec[9:8]};
         end else if (reg_addr == rsh_pkg::OFS_STATUS) begin
            nxt_q.rdata = {2'h0, q.cp_mid, q.cp_tri, q.holdover, q.sel_sec, q.present};
         end
      end

      loop_pd = q.reg_pwr[rsh_pkg::BIT_LOOP_PD];

      // Reference dividers count rising edges of the sampled inputs.
      div_eff[0] = div_limit(q.div_pri);
      div_eff[1] = q.reg_sw[rsh_pkg::BIT_INDEP_DIV] ? div_limit(q.div_sec) : div_eff[0];
      nxt_q.ref_prev = ref_in;
      for (int i = 0; i < 2; i++) begin
         if (loop_pd) begin
            nxt_q.edge_cnt[i] = 10'h000;
         end else if (ref_in[i] && !q.ref_prev[i]) begin
            if (q.edge_cnt[i] >= div_eff[i]) begin
               nxt_q.edge_cnt[i] = 10'h000;
               nxt_q.tick[i] = 1'b1;
            end else begin
               nxt_q.edge_cnt[i] = q.edge_cnt[i] + 10'h001;
            end
         end
      end

      // Presence monitor on the divided references.
      if (q.win_cnt >= MON_WINDOW - 12'h001) begin
         nxt_q.win_cnt = 12'h000;
         nxt_q.present = q.seen | q.tick;
         nxt_q.seen = 2'b00;
      end else begin
         nxt_q.win_cnt = q.win_cnt + 12'h001;
         nxt_q.seen = q.seen | q.tick;
      end

      // Switchover decision on registered presence.
      pres = q.present;
      mode = q.reg_sw[rsh_pkg::BIT_MODE_LO +: 2];
      want_sec = (mode == rsh_pkg::MODE_MAN_PIN) ? ref_select_pin : q.reg_sw[rsh_pkg::BIT_MAN_SEL];
      case (q.act)
         rsh_pkg::act_pri: begin
            if (mode == rsh_pkg::MODE_MAN_REG || mode == rsh_pkg::MODE_MAN_PIN) begin
               if (want_sec) begin
                  nxt_q.act = pres[1] ? rsh_pkg::act_sec : rsh_pkg::act_hold;
               end else if (!pres[0]) begin
                  nxt_q.act = rsh_pkg::act_hold;
               end
            end else if (!pres[0]) begin
               nxt_q.act = pres[1] ? rsh_pkg::act_sec : rsh_pkg::act_hold;
            end
         end
         rsh_pkg::act_sec: begin
            if (mode == rsh_pkg::MODE_MAN_REG || mode == rsh_pkg::MODE_MAN_PIN) begin
               if (!want_sec) begin
                  nxt_q.act = pres[0] ? rsh_pkg::act_pri : rsh_pkg::act_hold;
               end else if (!pres[1]) begin
                  nxt_q.act = rsh_pkg::act_hold;
               end
            end else if (!pres[1]) begin
               nxt_q.act = pres[0] ? rsh_pkg::act_pri : rsh_pkg::act_hold;
            end else if (mode == rsh_pkg::MODE_AUTO_REV && pres[0]) begin
               nxt_q.act = rsh_pkg::act_pri;
            end
         end
         default: begin
            if (mode == rsh_pkg::MODE_MAN_REG || mode == rsh_pkg::MODE_MAN_PIN) begin
               if (want_sec && pres[1]) begin
                  nxt_q.act = rsh_pkg::act_sec;
               end else if (!want_sec && pres[0]) begin
                  nxt_q.act = rsh_pkg::act_pri;
               end
            end else if (pres[0]) begin
               nxt_q.act = rsh_pkg::act_pri;
            end else if (pres[1]) begin
               nxt_q.act = rsh_pkg::act_sec;
            end
         end
      endcase

      // Outputs are registered copies of the next state, so the select never glitches.
      nxt_q.holdover = (nxt_q.act == rsh_pkg::act_hold);
      nxt_q.sel_sec = (nxt_q.act == rsh_pkg::act_sec);
      nxt_q.resync = q.holdover && !nxt_q.holdover;
      nxt_q.cp_mid = nxt_q.holdover && nxt_q.reg_sw[rsh_pkg::BIT_HOLD_MID];
      nxt_q.cp_tri = nxt_q.holdover && !nxt_q.reg_sw[rsh_pkg::BIT_HOLD_MID];

      // Receiver power control follows the configuration the same cycle it lands.
      for (int i = 0; i < 2; i++) begin
         nxt_q.diff_pd[i] = nxt_q.reg_pwr[rsh_pkg::BIT_LOOP_PD]
                            || nxt_q.reg_rx[rsh_pkg::BIT_PRI_SE + i];
         nxt_q.se_pd[i] = nxt_q.reg_pwr[rsh_pkg::BIT_LOOP_PD]
                          || nxt_q.reg_sepd[rsh_pkg::BIT_PRI_SE_PD + i]
                          || !nxt_q.reg_rx[rsh_pkg::BIT_PRI_SE + i];
      end
      nxt_q.osc_pd = nxt_q.reg_pwr[rsh_pkg::BIT_LOOP_PD];
      nxt_q.osc_mode = nxt_q.reg_rx[rsh_pkg::BIT_OSC_MODE_LO +: 2];
   end

   // Start in holdover: nothing is known to be present until a window has closed.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.act <= rsh_pkg::act_hold;
         q.holdover <= 1'b1;
         q.cp_tri <= 1'b1;
         q.reg_rx <= rsh_pkg::RST_REG;
         q.div_pri <= rsh_pkg::RST_DIV;
         q.div_sec <= rsh_pkg::RST_DIV;
         q.se_pd <= rsh_pkg::RST_SE_PD;
      end else begin
         q <= nxt_q;
      end
   end

   assign reg_rdata             = q.rdata;
   assign active_secondary      = q.sel_sec;
   assign holdover              = q.holdover;
   assign input_loop_resync     = q.resync;
   assign cp_tristate           = q.cp_tri;
   assign cp_midsupply          = q.cp_mid;
   assign ref_present           = q.present;
   assign ref_div_tick          = q.tick;
   assign diff_rx_pd            = q.diff_pd;
   assign se_buf_pd             = q.se_pd;
   assign oscillator_input_pd   = q.osc_pd;
   assign oscillator_input_mode = q.osc_mode;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   logic auto_mode;
   assign auto_mode = q.reg_sw[1];

   hold_entry_a: assert property (
      (auto_mode && q.present == 2'b00 && !reg_wr) |=> holdover
   ) else $error("no reference present but holdover not entered");

   cp_tristate_a: assert property (
      (holdover && !q.reg_sw[rsh_pkg::BIT_HOLD_MID]) |-> (cp_tristate && !cp_midsupply)
   ) else $error("charge pump not tristated in holdover");

   cp_midsupply_a: assert property (
      (holdover && q.reg_sw[rsh_pkg::BIT_HOLD_MID]) |-> (cp_midsupply && !cp_tristate)
   ) else $error("charge pump not at mid-supply in holdover");

   pump_idle_a: assert property (
      !holdover |-> !(cp_tristate || cp_midsupply)
   ) else $error("charge pump held while a reference is active");

   fail_over_a: assert property (
      (auto_mode && !reg_wr && !active_secondary && !holdover && q.present == 2'b10)
      |=> (active_secondary && !holdover)
   ) else $error("primary lost but secondary not taken");

   revert_a: assert property (
      (q.reg_sw[1:0] == rsh_pkg::MODE_AUTO_REV && !reg_wr && active_secondary && q.present[0])
      |=> !active_secondary && !holdover
   ) else $error("revertive mode did not return to primary");

   stay_secondary_a: assert property (
      (q.reg_sw[1:0] == rsh_pkg::MODE_AUTO_NR && !reg_wr && active_secondary && q.present[1])
      |=> active_secondary
   ) else $error("nonrevertive mode left a present secondary");

   resync_pulse_a: assert property (
      $fell(holdover) |-> input_loop_resync ##1 !input_loop_resync
   ) else $error("leaving holdover gave no single resync pulse");

   rx_power_a: assert property (
      oscillator_input_pd |-> (diff_rx_pd == 2'b11 && se_buf_pd == 2'b11)
   ) else $error("receivers left powered while the input loop is down");

   osc_power_a: assert property (
      $rose(q.reg_pwr[rsh_pkg::BIT_LOOP_PD]) |-> oscillator_input_pd
   ) else $error("oscillator receiver not powered down with the loop");

   // Two or more divided edges, each at least two cycles apart, keep ticks four cycles apart.
   div_spacing_a: assert property (
      (ref_div_tick[0] && q.div_pri > 10'h001 && !reg_wr) |=> !ref_div_tick[0] [*3]
   ) else $error("primary divider ticked too soon after the last tick");

   // Presence is reloaded on the edge that restarts the window, so only a zero count may see a change.
   window_a: assert property (
      (q.win_cnt != 12'h000) |-> $stable(ref_present)
   ) else $error("presence changed outside a window boundary");

   single_pri_a: assert property (
      (auto_mode && q.present == 2'b01) |=> (!holdover && !active_secondary)
   ) else $error("lone primary not made active");

   single_sec_a: assert property (
      (auto_mode && q.present == 2'b10) |=> (!holdover && active_secondary)
   ) else $error("lone secondary not made active");

   backup_kept_a: assert property (
      (auto_mode && q.present == 2'b11) |=> !holdover
   ) else $error("both references present but none active");

   manual_reg_a: assert property (
      (q.reg_sw[1:0] == rsh_pkg::MODE_MAN_REG && !q.reg_sw[rsh_pkg::BIT_MAN_SEL] && q.present[0])
      |=> (!holdover && !active_secondary)
   ) else $error("register selection of the primary ignored");

   manual_pin_a: assert property (
      (q.reg_sw[1:0] == rsh_pkg::MODE_MAN_PIN && ref_select_pin && q.present[1])
      |=> (!holdover && active_secondary)
   ) else $error("pin selection of the secondary ignored");

   resync_cause_a: assert property (
      input_loop_resync |-> $fell(holdover)
   ) else $error("resync pulse without leaving holdover");

   diff_off_a: assert property (
      q.reg_rx[rsh_pkg::BIT_PRI_SE] |-> diff_rx_pd[0]
   ) else $error("differential receiver powered while single-ended is chosen");

   se_off_a: assert property (
      !q.reg_rx[rsh_pkg::BIT_SEC_SE] |-> se_buf_pd[1]
   ) else $error("single-ended buffer powered while differential is chosen");

   osc_mode_a: assert property (
      oscillator_input_mode == q.reg_rx[rsh_pkg::BIT_OSC_MODE_LO +: 2]
   ) else $error("oscillator receiver mode differs from its field");

endmodule

`default_nettype wire

// ---- rsh_ref_src.sv ----
`timescale 1ns/100ps
`default_nettype none

// Two reference sources, synchronous to the oscillator clock.
// A running source gives a rising edge every 2 cycles, or every 4 when slow.
module rsh_ref_src (
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic [1:0] ref_en,
   input  wire logic [1:0] ref_slow,
   output logic            primary_reference,
   output logic            secondary_reference
);
   logic [1:0][1:0] phase_ff;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            phase_ff[i] <= ref_en[i] ? phase_ff[i] + 2'h1 : 2'h0;
         end
      end
   end

   // A lost source parks low, as a stopped oscillator would, so no stray edge reaches the divider.
   assign primary_reference   = ref_slow[0] ? phase_ff[0][1] : phase_ff[0][0];
   assign secondary_reference = ref_slow[1] ? phase_ff[1][1] : phase_ff[1][0];
endmodule

`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
   typedef struct packed {
      logic [7:0] sw;
      logic       pin;
      logic [1:0] en;
      logic [7:0] exp;
   } rsh_tb_row_s;

   localparam logic [11:0] WIN = 12'h010;
   logic        core_clk       = 1'h0;
   logic        nrst           = 1'h0;
   logic [11:0] reg_addr       = 12'h000;
   logic [7:0]  reg_wdata      = 8'h00;
   logic        reg_wr         = 1'h0;
   logic        reg_rd         = 1'h0;
   logic        ref_select_pin = 1'h0;
   logic [1:0]  ref_en         = 2'h0;
   logic [1:0]  ref_slow       = 2'h0;
   wire logic   primary_reference;
   wire logic   secondary_reference;
   logic [7:0]  reg_rdata;
   logic        active_secondary;
   logic        holdover;
   logic        input_loop_resync;
   logic        cp_tristate;
   logic        cp_midsupply;
   logic [1:0]  ref_present;
   logic [1:0]  ref_div_tick;
   logic [1:0]  diff_rx_pd;
   logic [1:0]  se_buf_pd;
   logic        oscillator_input_pd;
   logic [1:0]  oscillator_input_mode;
   int          n_mismatch      = 0;
   int          samples_checked = 0;
   int          cycles          = 0;
   int          k;
   logic [11:0] gap;

   // Switch value, select pin, sources running, expected status byte.
   rsh_tb_row_s rows [15] = '{
      '{8'h02, 1'h0, 2'h1, 8'h01},
      '{8'h02, 1'h0, 2'h3, 8'h03},
      '{8'h02, 1'h0, 2'h2, 8'h06},
      '{8'h02, 1'h0, 2'h3, 8'h07},
      '{8'h02, 1'h0, 2'h1, 8'h01},
      '{8'h03, 1'h0, 2'h2, 8'h06},
      '{8'h03, 1'h0, 2'h3, 8'h03},
      '{8'h03, 1'h0, 2'h0, 8'h18},
      '{8'h43, 1'h0, 2'h0, 8'h28},
      '{8'h43, 1'h0, 2'h2, 8'h06},
      '{8'h00, 1'h0, 2'h3, 8'h03},
      '{8'h04, 1'h0, 2'h3, 8'h07},
      '{8'h01, 1'h1, 2'h3, 8'h07},
      '{8'h01, 1'h0, 2'h3, 8'h03},
      '{8'h04, 1'h0, 2'h1, 8'h19}
   };

   rsh_ref_src src (.core_clk, .nrst, .ref_en, .ref_slow, .primary_reference, .secondary_reference);

   rsh_ctrl #(.MON_WINDOW(WIN)) uut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .primary_reference, .secondary_reference, .ref_select_pin, .active_secondary, .holdover,
      .input_loop_resync, .cp_tristate, .cp_midsupply, .ref_present, .ref_div_tick, .diff_rx_pd,
      .se_buf_pd, .oscillator_input_pd, .oscillator_input_mode);

   always #25 core_clk = ~core_clk;

   task automatic tally_and_finish;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // The ceiling sits well above the longest divider gap measured below.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic cmp(input logic [11:0] got, input logic [11:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      #1;
   endtask

   task automatic chk_reg(input logic [11:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1;
      cmp({4'h0, reg_rdata}, {4'h0, e}, "register read");
   endtask

   task automatic tick_gap(input int idx, output logic [11:0] g);
      int n;
      n = 0;
      // Let the divider settle after a divisor or speed change before timing a gap.
      repeat (16) @(posedge core_clk);
      #1;
      while (ref_div_tick[idx] !== 1'h1 && n < 5000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      g = 12'h000;
      do begin
         @(posedge core_clk);
         #1;
         g++;
      end while (ref_div_tick[idx] !== 1'h1 && g < 12'hfff);
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'h1;
      #1;
      cmp({cp_midsupply, cp_tristate, holdover, active_secondary, ref_present}, 12'h018, "reset state");
      cmp({oscillator_input_pd, diff_rx_pd, se_buf_pd}, 12'h003, "reset power");
      chk_reg(rsh_pkg::OFS_RX_MODE, 8'h00);
      chk_reg(rsh_pkg::OFS_SWITCH, 8'h00);
      chk_reg(rsh_pkg::OFS_PWR, 8'h00);
      chk_reg(rsh_pkg::OFS_DIVP_LO, 8'h01);
      chk_reg(12'h7ff, 8'h00);
      @(posedge core_clk);
      #1;
      cmp({4'h0, reg_rdata}, 12'h000, "read data held");
      // Both references single-ended, primary buffer off, oscillator receiver mode 2.
      wr(rsh_pkg::OFS_RX_MODE, 8'h62);
      wr(rsh_pkg::OFS_SE_PD, 8'h01);
      cmp({oscillator_input_mode, diff_rx_pd, se_buf_pd}, 12'h02d, "single-ended power");
      wr(rsh_pkg::OFS_PWR, 8'h04);
      cmp({oscillator_input_pd, diff_rx_pd, se_buf_pd}, 12'h01f, "loop power-down");
      wr(rsh_pkg::OFS_PWR, 8'h00);
      wr(rsh_pkg::OFS_RX_MODE, 8'h00);
      cmp({oscillator_input_pd, diff_rx_pd, se_buf_pd}, 12'h003, "differential power");
      for (int i = 0; i < 15; i++) begin
         wr(rsh_pkg::OFS_SWITCH, rows[i].sw);
         ref_select_pin <= rows[i].pin;
         ref_en <= rows[i].en;
         repeat (3 * WIN) @(posedge core_clk);
         #1;
         cmp({6'h00, cp_midsupply, cp_tristate, holdover, active_secondary, ref_present},
             {4'h0, rows[i].exp}, "selection outputs");
         chk_reg(rsh_pkg::OFS_STATUS, rows[i].exp);
      end
      wr(rsh_pkg::OFS_SWITCH, 8'h02);
      k = 0;
      while (holdover !== 1'h0 && k < 64) begin
         @(posedge core_clk);
         #1;
         k++;
      end
      cmp({holdover, input_loop_resync}, 12'h001, "holdover exit strobe");
      @(posedge core_clk);
      #1;
      cmp({11'h000, input_loop_resync}, 12'h000, "strobe length");
      wr(rsh_pkg::OFS_STATUS, 8'hff);
      chk_reg(rsh_pkg::OFS_STATUS, 8'h01);
      ref_en <= 2'h3;
      wr(rsh_pkg::OFS_DIVP_LO, 8'h03);
      tick_gap(0, gap);
      cmp(gap, 12'h006, "primary divide by 3");
      tick_gap(1, gap);
      cmp(gap, 12'h006, "secondary shares divisor");
      ref_slow <= 2'h1;
      tick_gap(0, gap);
      cmp(gap, 12'h00c, "slow primary");
      ref_slow <= 2'h0;
      wr(rsh_pkg::OFS_SWITCH, 8'h80);
      wr(rsh_pkg::OFS_DIVS_LO, 8'h05);
      tick_gap(1, gap);
      cmp(gap, 12'h00a, "independent secondary");
      wr(rsh_pkg::OFS_DIVP_HI, 8'h03);
      wr(rsh_pkg::OFS_DIVP_LO, 8'hff);
      tick_gap(0, gap);
      cmp(gap, 12'h7fe, "primary divide by 1023");
      tally_and_finish();
   end
endmodule

`default_nettype wire
